// *** pkg/bdc_pkg.sv ***
// constants of the background debug command unit
// assumes one 125 MHz core clock and a parallel command port that holds one whole command from the serial front end
package bdc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned RST_PULSE_CLKS = 512;
    localparam logic [9:0] RST_PULSE_CNT = 10'(RST_PULSE_CLKS);
    localparam logic [9:0] CNT_ZERO = 10'h000;
    localparam logic [9:0] CNT_ONE = 10'h001;

    // command opcodes, one consistent encoding for both ends
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_READ_DATA_REG = 4'h1;
    localparam logic [3:0] OP_READ_ADDR_REG = 4'h2;
    localparam logic [3:0] OP_WRITE_DATA_REG = 4'h3;
    localparam logic [3:0] OP_WRITE_ADDR_REG = 4'h4;
    localparam logic [3:0] OP_READ_SYS_REG = 4'h5;
    localparam logic [3:0] OP_WRITE_SYS_REG = 4'h6;
    localparam logic [3:0] OP_READ_MEM = 4'h7;
    localparam logic [3:0] OP_WRITE_MEM = 4'h8;
    localparam logic [3:0] OP_DUMP = 4'h9;
    localparam logic [3:0] OP_FILL = 4'ha;
    localparam logic [3:0] OP_GO = 4'hb;
    localparam logic [3:0] OP_CALL = 4'hc;
    localparam logic [3:0] OP_RST = 4'hd;

    // operand size codes
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;

    // system register index
    localparam logic [3:0] SYS_PC = 4'h0;
    localparam logic [3:0] SYS_SR = 4'h1;
    localparam logic [3:0] SYS_USP = 4'h2;
    localparam logic [3:0] SYS_SSP = 4'h3;
    localparam logic [3:0] SYS_VBR = 4'h4;
    localparam logic [3:0] SYS_SFC = 4'h5;
    localparam logic [3:0] SYS_DFC = 4'h6;

    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [15:0] SR_RESET = 16'h2700;
    // supervisor bit of the status register, and the address register that is the active stack pointer
    localparam int unsigned SR_SUP_BIT = 13;
    localparam int unsigned SP_IDX = 7;
    localparam logic [2:0] SPACE_RESET = 3'h5;
    localparam logic [31:0] STACK_STEP = 32'h0000_0004;
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD = 32'h0000_0002;
endpackage

// *** src/bdc_reset_pulse.sv ***
// peripheral reset pulse generator
// assumes a one-cycle start pulse from the command unit
`timescale 1ns/1ns
module bdc_reset_pulse
    import bdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // control
    input wire logic start,
    output logic periph_reset,
    output logic busy
);
    logic [9:0] cnt_q;
    logic [9:0] cnt_d;

    // a start while busy restarts the full count
    assign cnt_d = start ? RST_PULSE_CNT : (cnt_q != CNT_ZERO) ? cnt_q - CNT_ONE : CNT_ZERO;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign periph_reset = (cnt_q != CNT_ZERO);
    assign busy = periph_reset;
endmodule

// *** src/bdc_command_unit.sv ***
// background debug command unit: executes decoded debug commands on the core state
// assumes a serial front end that delivers one whole command per cmd_valid and takes results on rsp_valid
`timescale 1ns/1ns
module bdc_command_unit
    import bdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // command from the serial front end
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [3:0] cmd_op,
    input wire logic [1:0] cmd_size,
    input wire logic [3:0] cmd_reg,
    input wire logic [31:0] cmd_addr,
    input wire logic [31:0] cmd_data,
    // result to the serial front end
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    // memory port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [2:0] mem_space,
    output logic [1:0] mem_size,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // core control
    output logic pipe_flush,
    output logic run,
    output logic [31:0] pc_out,
    output logic periph_reset
);
    typedef enum logic [2:0] {BDC_IDLE, BDC_MEM, BDC_PUSH, BDC_FLUSH} bdc_state_t;

    bdc_state_t state_q;
    bdc_state_t state_d;
    logic [31:0] dreg_q [8];
    logic [31:0] areg_q [8];
    logic [31:0] pc_q;
    logic [15:0] sr_q;
    logic [31:0] usp_q;
    logic [31:0] vbr_q;
    logic [2:0] source_space_code_q;
    logic [2:0] destination_space_code_q;
    logic [31:0] blk_addr_q;
    logic [31:0] patch_q;
    logic mem_we_q;
    logic [1:0] mem_size_q;
    logic [31:0] mem_addr_q;
    logic [31:0] mem_wdata_q;
    logic [31:0] rsp_data_q;
    logic rsp_valid_q;
    logic run_q;
    logic flush_q;

    ////////////////////////////////////////////////////////////////////////////
    // decode
    wire take = cmd_valid && cmd_ready;
    wire is_read_data_reg_cmd = take && (cmd_op == OP_READ_DATA_REG);
    wire is_read_addr_reg_cmd = take && (cmd_op == OP_READ_ADDR_REG);
    wire is_write_data_reg_cmd = take && (cmd_op == OP_WRITE_DATA_REG);
    wire is_write_addr_reg_cmd = take && (cmd_op == OP_WRITE_ADDR_REG);
    wire is_read_system_reg_cmd = take && (cmd_op == OP_READ_SYS_REG);
    wire is_write_system_reg_cmd = take && (cmd_op == OP_WRITE_SYS_REG);
    wire is_rd_mem = take && (cmd_op == OP_READ_MEM);
    wire is_wr_mem = take && (cmd_op == OP_WRITE_MEM);
    wire is_dump = take && (cmd_op == OP_DUMP);
    wire is_fill = take && (cmd_op == OP_FILL);
    wire is_go = take && (cmd_op == OP_GO);
    wire is_call = take && (cmd_op == OP_CALL);
    wire is_rst = take && (cmd_op == OP_RST);
    wire [2:0] reg_idx = cmd_reg[2:0];
    wire sup_mode = sr_q[SR_SUP_BIT];
    wire [31:0] stack_ptr = areg_q[SP_IDX];

    // size step, used to advance the block address
    wire [31:0] size_step = (cmd_size == SZ_BYTE) ? STEP_BYTE : (cmd_size == SZ_WORD) ? STEP_WORD : STACK_STEP;
    wire [31:0] next_blk = blk_addr_q + size_step;

    // system register read mux
    logic [31:0] sys_rd;
    always_comb begin
        case (cmd_reg)
            SYS_PC: sys_rd = pc_q;
            SYS_SR: sys_rd = {16'h0000, sr_q};
            SYS_USP: sys_rd = sup_mode ? usp_q : stack_ptr;
            SYS_SSP: sys_rd = sup_mode ? stack_ptr : usp_q;
            SYS_VBR: sys_rd = vbr_q;
            SYS_SFC: sys_rd = {29'h0000_0000, source_space_code_q};
            SYS_DFC: sys_rd = {29'h0000_0000, destination_space_code_q};
            default: sys_rd = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            BDC_IDLE: begin
                if (is_rd_mem || is_wr_mem || is_dump || is_fill) begin
                    state_d = BDC_MEM;
                end else if (is_call) begin
                    state_d = BDC_PUSH;
                end else if (is_go) begin
                    state_d = BDC_FLUSH;
                end
            end
            BDC_MEM: begin
                if (mem_ack) begin
                    state_d = BDC_IDLE;
                end
            end
            BDC_PUSH: begin
                if (mem_ack) begin
                    state_d = BDC_FLUSH;
                end
            end
            BDC_FLUSH: state_d = BDC_IDLE;
            default: state_d = BDC_IDLE;
        endcase
    end

    // no new command while the core runs, a memory access is open or the reset pulse is out
    wire rst_busy;
    assign cmd_ready = (state_q == BDC_IDLE) && !run_q && !rst_busy;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= BDC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // general registers, one generate per register index
    for (genvar i = 0; i < 8; i++) begin : g_regs
        wire wr_d = is_write_data_reg_cmd && (reg_idx == 3'(i));
        wire wr_a = is_write_addr_reg_cmd && (reg_idx == 3'(i));
        wire wr_sp = (i == SP_IDX) && is_write_system_reg_cmd && (sup_mode ? (cmd_reg == SYS_SSP) : (cmd_reg == SYS_USP));
        wire push_sp = (i == SP_IDX) && (state_q == BDC_PUSH) && mem_ack;
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                dreg_q[i] <= 32'h0000_0000;
                areg_q[i] <= 32'h0000_0000;
            end else begin
                if (wr_d) begin
                    dreg_q[i] <= cmd_data;
                end
                if (wr_a || wr_sp) begin
                    areg_q[i] <= cmd_data;
                end else if (push_sp) begin
                    areg_q[i] <= areg_q[i] - STACK_STEP;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system registers
    wire wr_sys = is_write_system_reg_cmd;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc_q <= PC_RESET;
            sr_q <= SR_RESET;
            usp_q <= 32'h0000_0000;
            vbr_q <= 32'h0000_0000;
            source_space_code_q <= SPACE_RESET;
            destination_space_code_q <= SPACE_RESET;
        end else begin
            if (wr_sys && (cmd_reg == SYS_PC)) begin
                pc_q <= cmd_data;
            end else if ((state_q == BDC_PUSH) && mem_ack) begin
                pc_q <= patch_q;
            end
            if (wr_sys && (cmd_reg == SYS_SR)) begin
                sr_q <= cmd_data[15:0];
            end
            if (wr_sys && (sup_mode ? (cmd_reg == SYS_USP) : (cmd_reg == SYS_SSP))) begin
                usp_q <= cmd_data;
            end
            if (wr_sys && (cmd_reg == SYS_VBR)) begin
                vbr_q <= cmd_data;
            end
            if (wr_sys && (cmd_reg == SYS_SFC)) begin
                source_space_code_q <= cmd_data[2:0];
            end
            if (wr_sys && (cmd_reg == SYS_DFC)) begin
                destination_space_code_q <= cmd_data[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory access set-up
    wire mem_start = is_rd_mem || is_wr_mem || is_dump || is_fill;
    wire [31:0] acc_addr = (is_dump || is_fill) ? next_blk : cmd_addr;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            blk_addr_q <= 32'h0000_0000;
            mem_we_q <= 1'b0;
            mem_size_q <= SZ_LONG;
            mem_addr_q <= 32'h0000_0000;
            mem_wdata_q <= 32'h0000_0000;
            patch_q <= 32'h0000_0000;
        end else if (mem_start) begin
            blk_addr_q <= acc_addr;
            mem_we_q <= is_wr_mem || is_fill;
            mem_size_q <= cmd_size;
            mem_addr_q <= acc_addr;
            mem_wdata_q <= cmd_data;
        end else if (is_call) begin
            patch_q <= cmd_addr;
            mem_we_q <= 1'b1;
            mem_size_q <= SZ_LONG;
            mem_addr_q <= stack_ptr - STACK_STEP;
            mem_wdata_q <= pc_q;
        end
    end

    assign mem_req = (state_q == BDC_MEM) || (state_q == BDC_PUSH);
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_size = mem_size_q;
    assign mem_wdata = mem_wdata_q;
    assign mem_space = mem_we_q ? destination_space_code_q : source_space_code_q;

    ////////////////////////////////////////////////////////////////////////////
    // results; a null command falls through every branch and touches nothing
    wire rd_mem_done = (state_q == BDC_MEM) && mem_ack && !mem_we_q;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 32'h0000_0000;
        end else begin
            rsp_valid_q <= is_read_data_reg_cmd || is_read_addr_reg_cmd || is_read_system_reg_cmd || rd_mem_done;
            if (is_read_data_reg_cmd) begin
                rsp_data_q <= dreg_q[reg_idx];
            end else if (is_read_addr_reg_cmd) begin
                rsp_data_q <= areg_q[reg_idx];
            end else if (is_read_system_reg_cmd) begin
                rsp_data_q <= sys_rd;
            end else if (rd_mem_done) begin
                rsp_data_q <= mem_rdata;
            end
        end
    end
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;

    ////////////////////////////////////////////////////////////////////////////
    // execution control: flush one cycle, then leave background mode
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flush_q <= 1'b0;
            run_q <= 1'b0;
        end else begin
            flush_q <= (state_d == BDC_FLUSH);
            run_q <= run_q || (state_q == BDC_FLUSH);
        end
    end
    assign pipe_flush = flush_q;
    assign run = run_q;
    assign pc_out = pc_q;

    bdc_reset_pulse u_reset_pulse (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .start(is_rst),
        .periph_reset(periph_reset),
        .busy(rst_busy)
    );
endmodule

// *** dv/bdc_mem_model.sv ***
// memory partner model for the command unit's memory port
// assumes requests are held until mem_ack; lat sets the extra wait cycles
`timescale 1ns/1ns
module bdc_mem_model
    import bdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // memory port
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic [2:0] mem_space,
    input wire logic [1:0] mem_size,
    output logic mem_ack,
    output logic [31:0] mem_rdata,
    // wait cycles before each answer
    input wire logic [1:0] lat
);
    logic [1:0] wait_q;
    wire [31:0] full = mem_addr ^ 32'h5a5a_0000 ^ {29'h0, mem_space};
    // narrow data sits in the low bits
    wire [31:0] sized = mem_size == SZ_BYTE ? full & 32'h0000_00ff :
        mem_size == SZ_WORD ? full & 32'h0000_ffff : full;
    wire open = mem_req && !mem_ack;
    ////////////////////////////////////////////////////////////////
    // outside the ack cycle the read data toggles every cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
        end else if (open && wait_q >= lat) begin
            wait_q <= 2'h0;
            mem_ack <= 1'b1;
            mem_rdata <= sized;
        end else begin
            wait_q <= open ? wait_q + 2'h1 : 2'h0;
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// *** dv/bdc_command_unit_sva.sv ***
// assertion checker for the debug command unit
// assumes it is bound onto the ports of bdc_command_unit
`timescale 1ns/1ns
module bdc_cmd_sva
    import bdc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // command and result
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic [3:0] cmd_op,
    input wire logic rsp_valid,
    // memory and core
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic mem_ack,
    input wire logic pipe_flush,
    input wire logic run,
    input wire logic periph_reset
);
    wire take = cmd_valid && cmd_ready;
    wire reg_rd = take && (cmd_op == OP_READ_DATA_REG || cmd_op == OP_READ_ADDR_REG ||
        cmd_op == OP_READ_SYS_REG);
    logic [9:0] hi_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////
    // consecutive cycles with the reset line high
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hi_q <= CNT_ZERO;
        end else begin
            hi_q <= periph_reset ? hi_q + CNT_ONE : CNT_ZERO;
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_pulse_len: assert property ($fell(periph_reset) |-> hi_q == RST_PULSE_CNT)
        else $error("bad pulse length");
    chk_rst_start: assert property (take && cmd_op == OP_RST |=> periph_reset && !cmd_ready)
        else $error("no reset pulse");
    chk_reg_answer: assert property (reg_rd |=> rsp_valid)
        else $error("no register answer");
    chk_go_order: assert property (take && cmd_op == OP_GO |=> pipe_flush ##1 run)
        else $error("bad resume order");
    chk_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request moved");
    chk_mem_answer: assert property (mem_req && mem_ack && !mem_we |=> rsp_valid && !mem_req)
        else $error("no memory answer");
    chk_run_sticky: assert property (run |=> run && !cmd_ready)
        else $error("run dropped");
    chk_nop_quiet: assert property (take && cmd_op == OP_NOP |=> !mem_req && !rsp_valid && !pipe_flush)
        else $error("null command acted");
    cover property (take && cmd_op == OP_DUMP);
    cover property (take && cmd_op == OP_FILL);
    cover property (take && cmd_op == OP_CALL);
endmodule
////////////////////////////////////////////////////////////////
bind bdc_command_unit bdc_cmd_sva sva_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .rsp_valid(rsp_valid), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .pipe_flush(pipe_flush), .run(run), .periph_reset(periph_reset));

// *** dv/test_bdc_command_unit.sv ***
// self-checking bench for bdc_command_unit with its memory partner
// assumes the package encoding; inputs change by nonblocking assignment on the rising edge
`timescale 1ns/1ns
module test_bdc_command_unit;
    import bdc_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_op = OP_NOP;
    logic [3:0] cmd_reg = 4'h0;
    logic [1:0] cmd_size = SZ_LONG;
    logic [1:0] lat = 2'h0;
    logic [31:0] cmd_addr = 32'h0;
    logic [31:0] cmd_data = 32'h0;
    logic cmd_ready, rsp_valid, mem_req, mem_we, mem_ack, pipe_flush, run, periph_reset;
    logic [31:0] rsp_data, mem_addr, mem_wdata, mem_rdata, pc_out, v, a;
    logic [2:0] mem_space;
    logic [1:0] mem_size;
    logic [31:0] rng = 32'he46f;
    logic [31:0] dreg [8];
    logic [3:0] sx [5] = '{SYS_PC, SYS_USP, SYS_VBR, SYS_SFC, SYS_DFC};
    logic [31:0] exp_rsp [$];
    logic [71:0] exp_mem [$];
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int k, s, n;
    bdc_command_unit dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_size(cmd_size), .cmd_reg(cmd_reg), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_space(mem_space), .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .pipe_flush(pipe_flush), .run(run), .pc_out(pc_out), .periph_reset(periph_reset));
    bdc_mem_model mem_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_space(mem_space), .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .lat(lat));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    function automatic logic [31:0] msk(input logic [31:0] d, input logic [1:0] sz);
        return sz == SZ_BYTE ? d & 32'hff : sz == SZ_WORD ? d & 32'hffff : d;
    endfunction
    task automatic chk_val(input logic [71:0] got, input logic [71:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rsp(input logic [71:0] got);
        chk_val(got, exp_rsp.size() ? {40'h0, exp_rsp.pop_front()} : {72{1'b1}});
    endtask
    task automatic chk_mem(input logic [71:0] got);
        chk_val(got, exp_mem.size() ? exp_mem.pop_front() : {72{1'b1}});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // command held until an edge sees cmd_ready high
    task automatic send(input logic [3:0] op, input logic [1:0] sz, input logic [3:0] rg,
        input logic [31:0] ad, input logic [31:0] dt);
        @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_size <= sz;
        cmd_reg <= rg;
        cmd_addr <= ad;
        cmd_data <= dt;
        lat <= 2'(rnd());
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] op, input logic [3:0] rg, input logic [31:0] ex);
        exp_rsp.push_back(ex);
        send(op, SZ_LONG, rg, 32'h0, 32'h0);
    endtask
    // reads use space 3, writes space 2; block commands get a junk address
    task automatic acc(input logic [3:0] op, input logic [1:0] sz, input logic [31:0] ea, input logic [31:0] dt);
        logic we;
        we = op == OP_WRITE_MEM || op == OP_FILL;
        exp_mem.push_back({2'h0, we, we ? 3'h2 : 3'h3, sz, ea, we ? dt : 32'h0});
        if (!we)
            exp_rsp.push_back(msk(ea ^ 32'h5a5a_0003, sz));
        send(op, sz, 4'h0, op == OP_READ_MEM || op == OP_WRITE_MEM ? ea : rnd(), dt);
    endtask
    task automatic flow(input logic [31:0] pc);
        logic f;
        f = 1'b0;
        repeat (30) begin
            @(posedge sys_clk);
            f = f | (pipe_flush === 1'b1);
        end
        chk_val({f, run, cmd_ready, pc_out}, {3'b110, pc});
        $display("test flow done");
    endtask
    task automatic done(input string t);
        do @(posedge sys_clk); while (cmd_ready !== 1'b1 || exp_rsp.size() || exp_mem.size());
        $display("test %s done", t);
    endtask
    ////////////////////////////////////////////////////////////////
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    always @(posedge sys_clk) begin
        if (!sys_rst && rsp_valid === 1'b1)
            chk_rsp({40'h0, rsp_data});
        if (!sys_rst && mem_req === 1'b1 && mem_ack === 1'b1)
            chk_mem({2'h0, mem_we, mem_space, mem_size, mem_addr, mem_we ? mem_wdata : 32'h0});
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        chk_val({cmd_ready, run, periph_reset, mem_req, mem_space, mem_size}, {4'b1000, SPACE_RESET, SZ_LONG});
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (k = 0; k < 8; k++) begin
            dreg[k] = rnd();
            send(OP_WRITE_DATA_REG, SZ_LONG, 4'(k), 32'h0, dreg[k]);
        end
        send(OP_NOP, SZ_LONG, 4'h3, 32'h0, 32'hffff_ffff);
        for (k = 0; k < 8; k++)
            rd(OP_READ_DATA_REG, 4'(k), dreg[k]);
        for (k = 0; k < 7; k++) begin
            v = rnd();
            send(OP_WRITE_ADDR_REG, SZ_LONG, 4'(k), 32'h0, v);
            rd(OP_READ_ADDR_REG, 4'(k), v);
        end
        done("registers");
        rd(OP_READ_SYS_REG, SYS_SR, {16'h0, SR_RESET});
        for (k = 0; k < 5; k++) begin
            v = k == 3 ? 32'h3 : k == 4 ? 32'h2 : rnd() & 32'hffff_fffe;
            send(OP_WRITE_SYS_REG, SZ_LONG, sx[k], 32'h0, v);
            rd(OP_READ_SYS_REG, sx[k], v);
        end
        done("system registers");
        for (s = 0; s < 3; s++) begin
            a = rnd() & 32'h00ff_fff0;
            acc(OP_READ_MEM, 2'(s), a, 32'h0);
            acc(OP_DUMP, 2'(s), a + (32'h1 << s), 32'h0);
            acc(OP_DUMP, 2'(s), a + (32'h2 << s), 32'h0);
            acc(OP_WRITE_MEM, 2'(s), a, msk(rnd(), 2'(s)));
            acc(OP_FILL, 2'(s), a + (32'h1 << s), msk(rnd(), 2'(s)));
        end
        done("memory");
        send(OP_RST, SZ_LONG, 4'h0, 32'h0, 32'h0);
        n = 0;
        repeat (600) begin
            @(posedge sys_clk);
            n += int'(periph_reset === 1'b1);
        end
        chk_val(72'(n), 72'(RST_PULSE_CLKS));
        rd(OP_READ_DATA_REG, 4'h0, dreg[0]);
        done("reset pulse");
        send(OP_WRITE_SYS_REG, SZ_LONG, SYS_SSP, 32'h0, 32'h1000);
        send(OP_WRITE_SYS_REG, SZ_LONG, SYS_PC, 32'h0, 32'h200);
        exp_mem.push_back({2'h0, 1'b1, 3'h2, SZ_LONG, 32'h0ffc, 32'h200});
        send(OP_CALL, SZ_LONG, 4'h0, 32'h4000, 32'h0);
        flow(32'h4000);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        send(OP_WRITE_SYS_REG, SZ_LONG, SYS_PC, 32'h0, 32'h300);
        send(OP_GO, SZ_LONG, 4'h0, 32'h0, 32'h0);
        flow(32'h300);
        finish_test();
    end
endmodule
